// *** src/gsel_group_selector_block.sv ***
// setting group selector: arbitrates requests and holds the active group
//
// Functional notes
// [R01] up to eight groups, exactly one active
// [R02] default: group one only, logic idle
// [R03] several enabled groups: requests steer activation
// [R04] requests may be pulses or held levels
// [R05] simultaneous requests: lowest group number wins
// [R06] two held levels: higher priority active
// [R07] pulse-selected group latches until another request
// [R08] force enable overrides automatic requests entirely
// [R09] operator forces only enabled groups, enable set
// [R10] force cleared: held levels resume at once
// [R11] active group reported one to eight; status.active_group gives 0 to 7 (group one is 0)
// [R12] forced selection none or group, default none
// [R13] forced group stays until another request
// [R14] force enable defaults off, gates panel changes
// [R15] used count enables groups; new get defaults
// [R16] remote change refused under higher held level
// [R17] held group one blocks all others
// [R18] request for disabled group is rejected
`timescale 1ns/100ps
`include "gsel_consts.svh"
module gsel_group_selector_block
  import gsel_pkg::*;
#(
  parameter int GROUPS = `GSEL_GROUPS,
  parameter int HOLD_CYCLES = `GSEL_HOLD_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // group requests from logic and digital inputs
  input wire logic group_one_request,
  input wire logic group_two_request,
  input wire logic group_three_request,
  input wire logic group_four_request,
  input wire logic group_five_request,
  input wire logic group_six_request,
  input wire logic group_seven_request,
  input wire logic group_eight_request,
  // settings
  input wire gsel_pkg::gsel_cfg_type cfg,
  input wire gsel_pkg::gsel_remote_type remote_change,
  // state and events
  output gsel_pkg::gsel_status_type status,
  output gsel_pkg::gsel_event_type events,
  output gsel_pkg::gsel_mode_type mode
);
  import gsel_pkg::*;

  initial begin
    if (GROUPS != `GSEL_GROUPS) begin
      $error("gsel_group_selector_block: GROUPS must be eight");
    end
  end

  // lowest set bit wins; used only to pick the automatic winner, blocking checks use above()
  function automatic gsel_idx_type first_set(input gsel_mask_type m);
    gsel_idx_type idx;
    idx = `GSEL_GROUP_ONE;
    for (int g = `GSEL_GROUPS - 1; g >= 0; g--) begin
      if (m[g]) begin
        idx = gsel_idx_type'(g);
      end
    end
    return idx;
  endfunction

  // groups ahead of idx in priority
  function automatic gsel_mask_type above(input gsel_idx_type idx);
    gsel_mask_type m;
    m = `GSEL_MASK_ZERO;
    for (int g = 0; g < `GSEL_GROUPS; g++) begin
      m[g] = (gsel_idx_type'(g) < idx);
    end
    return m;
  endfunction

  function automatic gsel_mask_type count_mask(input gsel_idx_type cnt);
    gsel_mask_type m;
    m = `GSEL_MASK_ZERO;
    for (int g = 0; g < `GSEL_GROUPS; g++) begin
      m[g] = (gsel_idx_type'(g) <= cnt);
    end
    return m;
  endfunction

  gsel_mask_type req_raw;
  gsel_mask_type req_rise;
  gsel_mask_type req_held;
  assign req_raw = {group_eight_request, group_seven_request, group_six_request,
                    group_five_request, group_four_request, group_three_request,
                    group_two_request, group_one_request};

  gsel_request_classifier #(
    .GROUPS(GROUPS),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_classifier (
    .mclk(mclk),
    .rst_n(rst_n),
    .req_in(req_raw),
    .req_rise(req_rise),
    .req_held(req_held)
  );

  // registered state
  gsel_idx_type act_r, act_nxt;
  gsel_mask_type en_prev_r, en_prev_nxt;
  gsel_sel_type fsel_prev_r, fsel_prev_nxt;
  logic fen_prev_r, fen_prev_nxt;
  gsel_event_type ev_r, ev_nxt;
  gsel_mode_type mode_r, mode_nxt;

  // combinational helpers
  gsel_mask_type en_mask;
  gsel_mask_type cand;
  gsel_mask_type held_en;
  gsel_idx_type win;
  gsel_idx_type fidx;
  gsel_idx_type ridx;
  logic force_on;
  logic fsel_named;
  logic fsel_new;
  logic rem_named;

  always_comb begin
    en_mask = count_mask(cfg.enabled_group_count); // R15
    cand = (req_rise | req_held) & en_mask; // R04
    held_en = req_held & en_mask;
    win = first_set(cand); // R05 R06
    force_on = cfg.force_change_enable;
    fsel_named = (cfg.forced_group_select != `GSEL_SEL_NONE);
    fidx = gsel_idx_type'(cfg.forced_group_select - gsel_sel_type'(1));
    fsel_new = (cfg.forced_group_select != fsel_prev_r) || !fen_prev_r;
    rem_named = remote_change.valid && (remote_change.group != `GSEL_SEL_NONE);
    ridx = gsel_idx_type'(remote_change.group - gsel_sel_type'(1));
  end

  always_comb begin
    act_nxt = act_r;
    mode_nxt = mode_r;
    ev_nxt = '0;
    en_prev_nxt = en_mask;
    fsel_prev_nxt = cfg.forced_group_select;
    fen_prev_nxt = force_on;
    ev_nxt.newly_enabled = en_mask & ~en_prev_r; // R15
    if (cfg.enabled_group_count == `GSEL_COUNT_ONE_ONLY) begin
      // single group: nothing to arbitrate
      mode_nxt = GSEL_IDLE;
      act_nxt = `GSEL_GROUP_ONE; // R02
    end else if (!en_mask[act_r]) begin
      // active group just left the enabled set; fall back to group one
      act_nxt = `GSEL_GROUP_ONE;
      mode_nxt = force_on ? GSEL_FORCED : GSEL_AUTO;
    end else if (force_on) begin
      mode_nxt = GSEL_FORCED;
      // automatic inputs and remote parameter ignored here
      if (fsel_named) begin // R08 R12
        if (en_mask[fidx]) begin
          act_nxt = fidx; // R13
        end else begin
          ev_nxt.fail_unconfigured = fsel_new; // R18
        end
      end
    end else begin
      mode_nxt = GSEL_AUTO; // R03 R10
      if (rem_named && (req_rise & en_mask) == `GSEL_MASK_ZERO) begin
        // a fresh pulse outranks a remote write; a held level is judged by priority
        if (!en_mask[ridx]) begin
          ev_nxt.fail_unconfigured = 1'b1; // R18
          if (cand != `GSEL_MASK_ZERO) begin
            act_nxt = win;
          end
        end else if ((held_en & above(ridx)) != `GSEL_MASK_ZERO) begin
          ev_nxt.fail_lower_priority = 1'b1; // R16
          act_nxt = win; // R17
        end else begin
          act_nxt = ridx;
        end
      end else if (cand != `GSEL_MASK_ZERO) begin
        act_nxt = win; // R05 R06 R17
      end
      if (fsel_named && cfg.forced_group_select != fsel_prev_r) begin
        ev_nxt.fail_force_off = 1'b1; // R14
      end
    end
    ev_nxt.active_changed = (act_nxt != act_r);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= `GSEL_GROUP_ONE; // R02 R11
      mode_r <= GSEL_IDLE;
      ev_r <= '0;
      en_prev_r <= `GSEL_MASK_ONE;
      fsel_prev_r <= `GSEL_SEL_NONE;
      fen_prev_r <= 1'b0;
    end else begin
      act_r <= act_nxt;
      mode_r <= mode_nxt;
      ev_r <= ev_nxt;
      en_prev_r <= en_prev_nxt;
      fsel_prev_r <= fsel_prev_nxt;
      fen_prev_r <= fen_prev_nxt;
    end
  end

  // enabled_mask mirrors the registered view so status is all flop-driven
  always_comb begin
    status.active_group = act_r; // R11
    status.active_onehot = gsel_mask_type'(`GSEL_MASK_ONE << act_r); // R01
    status.enabled_mask = en_prev_r;
  end
  assign events = ev_r;
  assign mode = mode_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_force_release;
    force_on ##1 !force_on;
  endsequence

  sequence s_quiet_auto;
    !force_on && cand == `GSEL_MASK_ZERO && !remote_change.valid;
  endsequence

  a_single_onehot: assert property ($onehot(status.active_onehot)) // R01
    else $error("active group not exactly one");
  a_idle_group_one: assert property (
    cfg.enabled_group_count == `GSEL_COUNT_ONE_ONLY |=> act_r == `GSEL_GROUP_ONE) // R02
    else $error("single-group setting did not hold group one");
  a_auto_priority_win: assert property (
    !force_on && cand != `GSEL_MASK_ZERO && cfg.enabled_group_count != `GSEL_COUNT_ONE_ONLY
    && en_mask[act_r] && !remote_change.valid |=> act_r == $past(win)) // R05
    else $error("highest priority request not taken");
  a_group_one_blocks: assert property (
    !force_on && held_en[0] |=> act_r == `GSEL_GROUP_ONE) // R17
    else $error("held group one did not block others");
  a_pulse_latched: assert property (
    s_quiet_auto and (en_mask[act_r] && cfg.enabled_group_count != `GSEL_COUNT_ONE_ONLY)
    |=> $stable(act_r)) // R07
    else $error("latched group moved with no request");
  a_force_follows: assert property (
    force_on && fsel_named && en_mask[fidx] && en_mask[act_r]
    && cfg.enabled_group_count != `GSEL_COUNT_ONE_ONLY |=> act_r == $past(fidx)) // R08
    else $error("forced group not applied");
  a_force_ignores_req: assert property (
    force_on && !fsel_named && en_mask[act_r] |=> $stable(act_r)) // R08
    else $error("request acted while forcing");
  a_release_resume: assert property (
    s_force_release ##0 (held_en != `GSEL_MASK_ZERO && en_mask[act_r] && !remote_change.valid
    && cfg.enabled_group_count != `GSEL_COUNT_ONE_ONLY)
    |=> act_r == $past(win)) // R10
    else $error("held level did not resume after force release");
  a_remote_refused: assert property (
    !force_on && (req_rise & en_mask) == `GSEL_MASK_ZERO && rem_named && en_mask[ridx]
    && en_mask[act_r] && (held_en & above(ridx)) != `GSEL_MASK_ZERO
    && cfg.enabled_group_count != `GSEL_COUNT_ONE_ONLY
    |=> act_r == $past(win) && ev_r.fail_lower_priority) // R16
    else $error("remote change under higher held level not refused");
  a_unconf_rejected: assert property (
    !force_on && cand == `GSEL_MASK_ZERO && rem_named && !en_mask[ridx] && en_mask[act_r]
    |=> $stable(act_r) && ev_r.fail_unconfigured) // R18
    else $error("request for disabled group not rejected");
  a_new_groups_flag: assert property (
    en_mask[1] && !en_prev_r[1] |=> events.newly_enabled[1]) // R15
    else $error("newly enabled group not flagged");
endmodule

// *** src/gsel_consts.svh ***
// constants for the setting group selector
`ifndef GSEL_CONSTS_SVH
`define GSEL_CONSTS_SVH
`define GSEL_GROUPS 8
`define GSEL_IDX_W 3
`define GSEL_SEL_W 4
`define GSEL_SEL_NONE 4'h0
`define GSEL_GROUP_ONE 3'h0
`define GSEL_COUNT_ONE_ONLY 3'h0
`define GSEL_HOLD_CYCLES 2
`define GSEL_MASK_ZERO 8'h00
`define GSEL_MASK_ONE 8'h01
`endif

// *** src/gsel_pkg.sv ***
// types shared by the setting group selector files
`include "gsel_consts.svh"
package gsel_pkg;
  typedef logic [`GSEL_GROUPS-1:0] gsel_mask_type;
  typedef logic [`GSEL_IDX_W-1:0] gsel_idx_type;
  typedef logic [`GSEL_SEL_W-1:0] gsel_sel_type;
  typedef struct packed {
    logic force_change_enable;
    gsel_sel_type forced_group_select;
    gsel_idx_type enabled_group_count;
  } gsel_cfg_type;
  typedef struct packed {
    logic valid;
    gsel_sel_type group;
  } gsel_remote_type;
  typedef struct packed {
    gsel_idx_type active_group;
    gsel_mask_type active_onehot;
    gsel_mask_type enabled_mask;
  } gsel_status_type;
  typedef struct packed {
    logic active_changed;
    logic fail_unconfigured;
    logic fail_force_off;
    logic fail_lower_priority;
    gsel_mask_type newly_enabled;
  } gsel_event_type;
  typedef enum logic [1:0] {
    GSEL_IDLE,
    GSEL_AUTO,
    GSEL_FORCED
  } gsel_mode_type;
endpackage

// *** src/gsel_request_classifier.sv ***
// sorts each group request into a one-shot pulse and a held level
`timescale 1ns/100ps
`include "gsel_consts.svh"
module gsel_request_classifier #(
  parameter int GROUPS = `GSEL_GROUPS,
  parameter int HOLD_CYCLES = `GSEL_HOLD_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // raw requests
  input wire logic [GROUPS-1:0] req_in,
  // classified requests
  output logic [GROUPS-1:0] req_rise,
  output logic [GROUPS-1:0] req_held
);
  localparam int CW = $clog2(HOLD_CYCLES) + 1;

  initial begin
    if (HOLD_CYCLES < 2 || GROUPS < 1) begin
      $error("gsel_request_classifier: HOLD_CYCLES must be 2 or more");
    end
  end

  logic [CW-1:0] run_r [GROUPS];
  logic [CW-1:0] run_nxt [GROUPS];

  always_comb begin
    for (int g = 0; g < GROUPS; g++) begin
      run_nxt[g] = run_r[g];
      if (!req_in[g]) begin
        run_nxt[g] = '0;
      end else if (run_r[g] < CW'(HOLD_CYCLES - 1)) begin
        run_nxt[g] = run_r[g] + CW'(1);
      end
      // a level counts only once it has stood long enough; its first cycle is a pulse
      req_rise[g] = req_in[g] && (run_r[g] == '0); // R04
      req_held[g] = req_in[g] && (run_r[g] >= CW'(HOLD_CYCLES - 1)); // R04
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < GROUPS; g++) begin
        run_r[g] <= '0;
      end
    end else begin
      run_r <= run_nxt;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_rise_once_only: assert property (req_rise[0] |=> !req_rise[0]) // R04
    else $error("request pulse seen on two cycles in a row");
endmodule

// *** tb/gsel_req_source.sv ***
// request source standing in for digital inputs and internal logic
`timescale 1ns/100ps
module gsel_req_source (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // commands from the bench
  input wire logic [7:0] pulse_cmd,
  input wire logic [7:0] level_cmd,
  // request lines
  output logic [7:0] req
);
  logic [7:0] seen_r;
  logic [7:0] seen_nxt;
  always_comb begin
    seen_nxt = pulse_cmd;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 8'h00;
    end else begin
      seen_r <= seen_nxt;
    end
  end
  // a held pulse command still yields one high cycle only
  assign req = level_cmd | (pulse_cmd & ~seen_r);
endmodule

// *** tb/tb.sv ***
// self-checking bench for the setting group selector
`timescale 1ns/100ps
module tb;
  import gsel_pkg::*;
  logic mclk;
  logic rst_n;
  logic [7:0] pulse_cmd;
  logic [7:0] level_cmd;
  logic [7:0] req;
  gsel_cfg_type cfg;
  gsel_remote_type remote_change;
  gsel_status_type status;
  gsel_event_type events;
  gsel_mode_type mode;
  int mismatches;
  int compares;
  int cycles;
  logic [7:0] m;

  gsel_req_source u_gsel_req_source (.mclk(mclk), .rst_n(rst_n), .pulse_cmd(pulse_cmd),
    .level_cmd(level_cmd), .req(req));
  gsel_group_selector_block u_gsel_group_selector_block (.mclk(mclk), .rst_n(rst_n),
    .group_one_request(req[0]), .group_two_request(req[1]), .group_three_request(req[2]),
    .group_four_request(req[3]), .group_five_request(req[4]), .group_six_request(req[5]),
    .group_seven_request(req[6]), .group_eight_request(req[7]), .cfg(cfg),
    .remote_change(remote_change), .status(status), .events(events), .mode(mode));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles = cycles + 1;
    // generous ceiling, the tests need well under a thousand cycles
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_act(input logic [7:0] exp);
    check("active_group", 8'(status.active_group), exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic pulse(input logic [7:0] mask);
    @(posedge mclk);
    pulse_cmd <= mask;
    @(posedge mclk);
    pulse_cmd <= 8'h00;
    #1;
  endtask

  task automatic remote(input logic [3:0] grp);
    @(posedge mclk);
    remote_change <= '{valid: 1'b1, group: grp};
    @(posedge mclk);
    remote_change <= '{valid: 1'b0, group: 4'h0};
    #1;
  endtask

  function automatic logic [7:0] lowest(input logic [7:0] mask);
    for (int i = 7; i >= 0; i--) begin
      if (mask[i]) begin
        lowest = 8'(i);
      end
    end
  endfunction

  initial begin
    rst_n = 1'b0;
    pulse_cmd = 8'h00;
    level_cmd = 8'h00;
    cfg = '0;
    remote_change = '0;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    void'($urandom(32'h206680a3));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    tick(2);
    chk_act(8'h00);
    check("active_onehot", status.active_onehot, 8'h01);
    check("mode", 8'(mode), 8'(GSEL_IDLE));
    pulse(8'h04);
    chk_act(8'h00);
    $display("test defaults done");
    @(posedge mclk);
    cfg.enabled_group_count <= 3'h7;
    tick(1);
    check("newly_enabled", events.newly_enabled, 8'hfe);
    check("enabled_mask", status.enabled_mask, 8'hff);
    pulse(8'h04);
    chk_act(8'h02);
    check("active_changed", 8'(events.active_changed), 8'h01);
    tick(5);
    chk_act(8'h02);
    for (int i = 0; i < 20; i++) begin
      m = 8'($urandom_range(1, 255));
      pulse(m);
      chk_act(lowest(m));
    end
    $display("test pulse priority done");
    @(posedge mclk);
    level_cmd <= 8'h12;
    tick(4);
    chk_act(8'h01);
    pulse(8'h08);
    chk_act(8'h01);
    @(posedge mclk);
    level_cmd <= 8'h01;
    tick(4);
    for (int i = 0; i < 8; i++) begin
      pulse(8'($urandom_range(1, 255)) & 8'hfe);
      chk_act(8'h00);
    end
    @(posedge mclk);
    level_cmd <= 8'h02;
    tick(4);
    remote(4'h4);
    chk_act(8'h01);
    check("fail_lower", 8'(events.fail_lower_priority), 8'h01);
    @(posedge mclk);
    level_cmd <= 8'h00;
    tick(2);
    remote(4'h5);
    chk_act(8'h04);
    $display("test levels and remote done");
    // enable first, then name the group
    @(posedge mclk);
    cfg.force_change_enable <= 1'b1;
    tick(1);
    @(posedge mclk);
    cfg.forced_group_select <= 4'h7;
    tick(1);
    chk_act(8'h06);
    check("mode", 8'(mode), 8'(GSEL_FORCED));
    pulse(8'($urandom_range(1, 255)));
    chk_act(8'h06);
    @(posedge mclk);
    cfg.force_change_enable <= 1'b0;
    tick(5);
    chk_act(8'h06);
    @(posedge mclk);
    cfg.forced_group_select <= 4'h3;
    tick(1);
    check("fail_force_off", 8'(events.fail_force_off), 8'h01);
    chk_act(8'h06);
    @(posedge mclk);
    cfg.force_change_enable <= 1'b1;
    tick(1);
    chk_act(8'h02);
    @(posedge mclk);
    level_cmd <= 8'h20;
    tick(4);
    chk_act(8'h02);
    @(posedge mclk);
    cfg.force_change_enable <= 1'b0;
    tick(2);
    chk_act(8'h05);
    check("mode", 8'(mode), 8'(GSEL_AUTO));
    $display("test force done");
    @(posedge mclk);
    level_cmd <= 8'h00;
    cfg.enabled_group_count <= 3'h2;
    tick(2);
    check("enabled_mask", status.enabled_mask, 8'h07);
    chk_act(8'h00);
    pulse(8'h40);
    chk_act(8'h00);
    remote(4'h6);
    check("fail_unconf", 8'(events.fail_unconfigured), 8'h01);
    chk_act(8'h00);
    @(posedge mclk);
    cfg.force_change_enable <= 1'b1;
    tick(1);
    chk_act(8'h02);
    @(posedge mclk);
    cfg.forced_group_select <= 4'h8;
    tick(1);
    check("fail_unconf", 8'(events.fail_unconfigured), 8'h01);
    chk_act(8'h02);
    $display("test disabled groups done");
    finish_test();
  end
endmodule
